// ---- hdl/pgp_pkg.sv ----
// Purpose: Shared constants and types for the packet GPIO port.
// Assumes: 50 MHz clock, five pins, set and read command packets.
// Notes: Counts above 4096 cycles are defaults for top parameters.
package pgp_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int NPINS = 5;
  localparam int CLK_HZ = 50_000_000;
  localparam int SAMPLE_HZ = 32;
  localparam int PWM_HZ = 100;
  localparam int PWM_STEPS = 100;
  // Sample period and step period are both exact at 50 MHz
  localparam int SAMPLE_CYC_DEF = CLK_HZ / SAMPLE_HZ;
  localparam int STEP_CYC_DEF = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int SAMPLE_CNT_W = 21;
  localparam int STEP_CNT_W = 13;
  localparam int PHASE_W = 7;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 7'h63;

  // ----------------------------------------------------------------
  // Packet codes and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_SET = 8'h22;
  localparam logic [7:0] CODE_READ = 8'h23;
  localparam logic [7:0] REPLY_FLAG = 8'h40;
  localparam logic [7:0] LEN_VALUE = 8'h02;
  localparam logic [7:0] LEN_CONFIG = 8'h03;
  localparam logic [7:0] LEN_NONE = 8'h00;
  localparam logic [7:0] LEN_READ_RSP = 8'h04;
  localparam logic [7:0] LEVEL_HIGH = 8'h64;
  localparam logic [7:0] PIN_LAST = 8'h04;
  localparam int STATE_BIT = 0;
  localparam int FALL_BIT = 1;
  localparam int RISE_BIT = 2;
  localparam int FUNC_BIT = 3;

  // ----------------------------------------------------------------
  // Drive modes and power-up defaults
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_UP_PD = 3'h0;
  localparam logic [2:0] MODE_PUSH = 3'h1;
  localparam logic [2:0] MODE_HIZ = 3'h2;
  localparam logic [2:0] MODE_PU_DN = 3'h3;
  localparam logic [2:0] MODE_SUP_Z = 3'h4;
  localparam logic [2:0] MODE_SPUSH = 3'h5;
  localparam logic [2:0] MODE_RSVD = 3'h6;
  localparam logic [2:0] MODE_Z_SDN = 3'h7;
  // Pin 4..0: open drain, hi-z, hi-z, pull up, hi-z
  localparam logic [NPINS*3-1:0] MODE_DEF = 15'h749A;
  localparam logic [7:0] LEVEL_DEF = 8'h00;
  localparam logic FUNC_DEF = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CK_NONE = 2'b00,
    CK_SET = 2'b01,
    CK_READ = 2'b10
  } pgp_kind_e;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [7:0] len;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] d2;
  } pgp_cmd_s;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [7:0] len;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] d3;
  } pgp_rsp_s;

  typedef struct packed {
    logic [7:0] level;
    logic func;
    logic [2:0] mode;
  } pgp_cfg_s;

endpackage : pgp_pkg

// ---- hdl/pgp_timebase.sv ----
// Purpose: Sample tick and shared PWM phase for all pins.
// Assumes: Clock enable freezes both counters.
// Notes: One counter pair serves every pin, so all PWM edges align.
`timescale 1ns/1ps
module pgp_timebase
  import pgp_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = SAMPLE_CYC_DEF,
  parameter int unsigned STEP_CYC = STEP_CYC_DEF
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Timing outputs
  output logic sample_tick_o,
  output logic [PHASE_W-1:0] phase_o
);

  logic [SAMPLE_CNT_W-1:0] scnt_q, scnt_d;
  logic [STEP_CNT_W-1:0] pcnt_q, pcnt_d;
  logic [PHASE_W-1:0] phase_q, phase_d;
  logic tick_q, tick_d;

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // Next values of sample and step counters
  always_comb begin
    scnt_d = scnt_q;
    pcnt_d = pcnt_q;
    phase_d = phase_q;
    tick_d = tick_q;
    if (ce_i) begin
      tick_d = 1'b0;
      scnt_d = scnt_q + 1'b1;
      if (scnt_q == SAMPLE_CNT_W'(SAMPLE_CYC - 1)) begin
        scnt_d = '0;
        tick_d = 1'b1; // R9
      end
      pcnt_d = pcnt_q + 1'b1;
      if (pcnt_q == STEP_CNT_W'(STEP_CYC - 1)) begin
        pcnt_d = '0;
        phase_d = (phase_q == PHASE_LAST) ? '0 : phase_q + 1'b1; // R18
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scnt_q <= '0;
      pcnt_q <= '0;
      phase_q <= '0;
      tick_q <= 1'b0;
    end else begin
      scnt_q <= scnt_d;
      pcnt_q <= pcnt_d;
      phase_q <= phase_d;
      tick_q <= tick_d;
    end
  end

  assign sample_tick_o = tick_q;
  assign phase_o = phase_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  phase_range_a: assert property (phase_q <= PHASE_LAST) // R18
    else $error("PWM phase left its 100-step range");
  tick_single_a: assert property (tick_q && ce_i |=> !tick_q) // R9
    else $error("Sample tick lasted more than one cycle");

endmodule : pgp_timebase

// ---- hdl/pgp_pin_drive.sv ----
// Purpose: Turns a pin level and drive mode into pad controls.
// Assumes: Pad has strong driver, slow-edge option and weak pulls.
// Notes: Purely combinational; the top registers every result.
`timescale 1ns/1ps
module pgp_pin_drive
  import pgp_pkg::*;
(
  // Requested level and mode
  input wire logic level_i,
  input wire logic [2:0] mode_i,
  // Pad controls
  output logic oe_o,
  output logic out_o,
  output logic pu_o,
  output logic pd_o,
  output logic slow_o
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Strong drive wins over pulls; pulls only when not driving
  always_comb begin
    oe_o = 1'b0;
    out_o = level_i;
    pu_o = 1'b0;
    pd_o = 1'b0;
    slow_o = 1'b0;
    unique case (mode_i)
      MODE_UP_PD: begin
        oe_o = level_i; // R4
        pd_o = !level_i;
      end
      MODE_PUSH: oe_o = 1'b1; // R4
      MODE_HIZ: oe_o = 1'b0; // R6
      MODE_PU_DN: begin
        oe_o = !level_i; // R4
        pu_o = level_i;
      end
      MODE_SUP_Z: begin
        oe_o = level_i; // R5
        slow_o = 1'b1;
      end
      MODE_SPUSH: begin
        oe_o = 1'b1; // R5
        slow_o = 1'b1;
      end
      MODE_RSVD: oe_o = 1'b0; // Reserved: stay off the wire
      MODE_Z_SDN: begin
        oe_o = !level_i; // R5
        slow_o = 1'b1;
      end
    endcase
  end

endmodule : pgp_pin_drive

// ---- hdl/pgp_port.sv ----
// Purpose: Five-pin GPIO port driven by set and read command packets.
// Assumes: Packets arrive parsed, one-cycle valid; pins are synchronous.
// Notes: Boot copy is saved and restored by strobes from the host path.
//
// Notes on behaviour
// [R1] Index 0..4 picks a pin; rest reserved
// [R2] Level 0 low, 100 high, 1..99 PWM
// [R3] Two bytes set value; three add config
// [R4] Modes 000, 001, 011 drive as listed
// [R5] Modes 100, 101, 111 slow, as listed
// [R6] Mode 010 is input; 110 reserved
// [R7] Function bit picks user or default role
// [R8] Host keeps config byte within 0..15
// [R9] Sample all pins steadily at 32 Hz
// [R10] Latch edges since last read, then clear
// [R11] Reply state byte: level, fall, rise
// [R12] Report sampled level, not requested one
// [R13] Reply returns stored level and config nibble
// [R14] Read code 0x23 echoes pin index
// [R15] Set code 0x22 acked by empty 0x62
// [R16] Pins 2, 3, 4 default to host roles
// [R17] Pin config belongs to saved boot state
// [R18] Common 100-step counter makes PWM
`timescale 1ns/1ps
module pgp_port
  import pgp_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = SAMPLE_CYC_DEF,
  parameter int unsigned STEP_CYC = STEP_CYC_DEF
) (
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // Command packets and replies
  input wire pgp_cmd_s CMD_I,
  output pgp_rsp_s RSP_O,
  // Boot state strobes
  input wire logic SAVE_BOOT_I,
  input wire logic LOAD_BOOT_I,
  // Default-role levels (power, reset, one_wire_port)
  input wire logic [NPINS-1:0] DEF_LEVEL_I,
  // Pads
  input wire logic [NPINS-1:0] PIN_I,
  output logic [NPINS-1:0] PIN_O,
  output logic [NPINS-1:0] PIN_OE_O,
  output logic [NPINS-1:0] PIN_PU_O,
  output logic [NPINS-1:0] PIN_PD_O,
  output logic [NPINS-1:0] PIN_SLOW_O
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  // Async assert, two-stage release
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  logic tick;
  logic [PHASE_W-1:0] phase;

  pgp_timebase #(
    .SAMPLE_CYC(SAMPLE_CYC),
    .STEP_CYC(STEP_CYC)
  ) u_timebase (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .ce_i(CE_I),
    .sample_tick_o(tick),
    .phase_o(phase)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  pgp_kind_e kind;
  logic idx_ok;
  logic [2:0] idx;

  // Only our two codes are acted on; others belong elsewhere
  always_comb begin
    kind = CK_NONE;
    if (CMD_I.valid && CE_I) begin
      if (CMD_I.code == CODE_SET) begin
        kind = CK_SET; // R15
      end else if (CMD_I.code == CODE_READ) begin
        kind = CK_READ; // R14
      end
    end
  end
  assign idx_ok = (CMD_I.d0 <= PIN_LAST); // R1
  assign idx = CMD_I.d0[2:0];

  // ----------------------------------------------------------------
  // Pin configuration and boot copy
  // ----------------------------------------------------------------
  pgp_cfg_s cfg_q [NPINS];
  pgp_cfg_s cfg_d [NPINS];
  pgp_cfg_s boot_q [NPINS];
  pgp_cfg_s boot_d [NPINS];
  logic [NPINS-1:0] smp_q, smp_d, rise_q, rise_d, fall_q, fall_d;
  logic [NPINS-1:0] lvl, oe_n, out_n, pu_n, pd_n, slow_n;
  logic [NPINS-1:0] out_q, oe_q, pu_q, pd_q, slow_q;
  logic [NPINS-1:0] clr;

  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    // Config update: value only, or value plus nibble
    always_comb begin
      cfg_d[i] = cfg_q[i];
      boot_d[i] = boot_q[i];
      if (CE_I) begin
        if (SAVE_BOOT_I) begin
          boot_d[i] = cfg_q[i]; // R17
        end
        if (LOAD_BOOT_I) begin
          cfg_d[i] = boot_q[i]; // R17
        end else if (kind == CK_SET && idx_ok && idx == 3'(i)) begin
          if (CMD_I.d1 <= LEVEL_HIGH) begin
            cfg_d[i].level = CMD_I.d1; // R2
          end
          if (CMD_I.len == LEN_CONFIG) begin
            cfg_d[i].func = CMD_I.d2[FUNC_BIT]; // R3
            cfg_d[i].mode = CMD_I.d2[2:0]; // R3
          end
        end
      end
    end

    // Sampling and edge flags; a new edge beats a read's clear
    always_comb begin
      clr[i] = (kind == CK_READ) && idx_ok && (idx == 3'(i));
      smp_d[i] = smp_q[i];
      rise_d[i] = rise_q[i] && !clr[i]; // R10
      fall_d[i] = fall_q[i] && !clr[i]; // R10
      if (CE_I && tick) begin
        smp_d[i] = PIN_I[i]; // R9
        if (PIN_I[i] && !smp_q[i]) begin
          rise_d[i] = 1'b1; // R10
        end
        if (!PIN_I[i] && smp_q[i]) begin
          fall_d[i] = 1'b1; // R10
        end
      end
    end

    // User role takes PWM level; else the default role's level
    assign lvl[i] = cfg_q[i].func ? (phase < cfg_q[i].level[PHASE_W-1:0] ||
                                     cfg_q[i].level == LEVEL_HIGH)
                                  : DEF_LEVEL_I[i]; // R7 R2 R16

    pgp_pin_drive u_drive (
      .level_i(lvl[i]),
      .mode_i(cfg_q[i].mode),
      .oe_o(oe_n[i]),
      .out_o(out_n[i]),
      .pu_o(pu_n[i]),
      .pd_o(pd_n[i]),
      .slow_o(slow_n[i])
    );

    // Register stage; power-up config holds the host-role defaults
    always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
        cfg_q[i] <= '{LEVEL_DEF, FUNC_DEF, MODE_DEF[i*3 +: 3]}; // R16
        boot_q[i] <= '{LEVEL_DEF, FUNC_DEF, MODE_DEF[i*3 +: 3]};
        smp_q[i] <= 1'b0;
        rise_q[i] <= 1'b0;
        fall_q[i] <= 1'b0;
        out_q[i] <= 1'b0;
        oe_q[i] <= 1'b0;
        pu_q[i] <= 1'b0;
        pd_q[i] <= 1'b0;
        slow_q[i] <= 1'b0;
      end else begin
        cfg_q[i] <= cfg_d[i];
        boot_q[i] <= boot_d[i];
        smp_q[i] <= smp_d[i];
        rise_q[i] <= rise_d[i];
        fall_q[i] <= fall_d[i];
        if (CE_I) begin
          out_q[i] <= out_n[i];
          oe_q[i] <= oe_n[i];
          pu_q[i] <= pu_n[i];
          pd_q[i] <= pd_n[i];
          slow_q[i] <= slow_n[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Replies
  // ----------------------------------------------------------------
  pgp_rsp_s rsp_q, rsp_d;

  // Reply is built from state before this cycle's updates
  always_comb begin
    rsp_d = rsp_q;
    if (CE_I) begin
      rsp_d = '0;
      rsp_d.code = CMD_I.code | REPLY_FLAG;
      if (kind == CK_SET) begin
        rsp_d.valid = 1'b1; // R15
        rsp_d.len = LEN_NONE;
      end else if (kind == CK_READ) begin
        rsp_d.valid = 1'b1;
        rsp_d.len = LEN_READ_RSP;
        rsp_d.d0 = CMD_I.d0; // R14
        // Reserved index answers with zeros past the echo
        if (idx_ok) begin
          rsp_d.d1[STATE_BIT] = smp_q[idx]; // R11 R12
          rsp_d.d1[FALL_BIT] = fall_q[idx]; // R11
          rsp_d.d1[RISE_BIT] = rise_q[idx]; // R11
          rsp_d.d2 = cfg_q[idx].level; // R13
          rsp_d.d3 = {4'h0, cfg_q[idx].func, cfg_q[idx].mode}; // R13
        end
      end else begin
        rsp_d.code = '0;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign RSP_O = rsp_q;
  assign PIN_O = out_q;
  assign PIN_OE_O = oe_q;
  assign PIN_PU_O = pu_q;
  assign PIN_PD_O = pd_q;
  assign PIN_SLOW_O = slow_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  sequence set_seen;
    kind == CK_SET;
  endsequence
  sequence ack_empty;
    RSP_O.valid && RSP_O.code == (CODE_SET | REPLY_FLAG) && RSP_O.len == LEN_NONE;
  endsequence

  set_ack_a: assert property (set_seen |=> ack_empty) // R15
    else $error("Set command not acknowledged with empty reply");
  read_echo_a: assert property (kind == CK_READ |=> // R14
      RSP_O.valid && RSP_O.code == (CODE_READ | REPLY_FLAG) && RSP_O.d0 == $past(CMD_I.d0))
    else $error("Read reply does not echo the pin index");
  reply_resv_a: assert property (RSP_O.valid && RSP_O.code == (CODE_READ | REPLY_FLAG) |-> // R11
      RSP_O.d1[7:3] == 5'h00 && RSP_O.d3[7:4] == 4'h0 && RSP_O.d2 <= LEVEL_HIGH)
    else $error("Read reply has reserved bits set");
  edge_clear_a: assert property (kind == CK_READ && idx_ok && !tick |=> // R10
      rise_q[$past(idx)] == 1'b0 && fall_q[$past(idx)] == 1'b0)
    else $error("Edge flags not cleared by read");
  rise_latch_a: assert property (CE_I && tick && PIN_I[0] && !smp_q[0] |=> // R10
      rise_q[0] && smp_q[0])
    else $error("Rising edge on pin 0 not latched");
  sample_hold_a: assert property (!tick |=> $stable(smp_q)) // R9
    else $error("Pins sampled outside the sample tick");
  value_only_a: assert property (kind == CK_SET && CMD_I.len == LEN_VALUE && // R3
      idx == 3'h0 && idx_ok && !LOAD_BOOT_I |=> $stable(cfg_q[0].mode))
    else $error("Two-byte set changed pin 0 drive mode");
  bad_level_a: assert property (kind == CK_SET && CMD_I.d1 > LEVEL_HIGH && // R2
      idx == 3'h0 && idx_ok && !LOAD_BOOT_I |=> $stable(cfg_q[0].level))
    else $error("Invalid output level was stored");
  hiz_mode_a: assert property (CE_I && cfg_q[2].mode == MODE_HIZ |=> // R6
      !PIN_OE_O[2])
    else $error("Pin 2 driven while in input mode");
  push_mode_a: assert property (CE_I && cfg_q[0].mode == MODE_PUSH |=> // R4
      PIN_OE_O[0] && PIN_O[0] == $past(lvl[0]))
    else $error("Pin 0 not driven in push-pull mode");

endmodule : pgp_port

// ---- testbench/pgp_pin_load.sv ----
// Purpose: External circuit on the five pads, resolving each wire level.
// Assumes: Pads are synchronous to the port clock.
// Notes: A pin nobody drives or pulls toggles every cycle.
`timescale 1ns/1ps
module pgp_pin_load
  import pgp_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Pad controls from the port
  input wire logic [NPINS-1:0] out_i,
  input wire logic [NPINS-1:0] oe_i,
  input wire logic [NPINS-1:0] pu_i,
  input wire logic [NPINS-1:0] pd_i,
  // External source on the wire
  input wire logic [NPINS-1:0] ext_en_i,
  input wire logic [NPINS-1:0] ext_lvl_i,
  // Resolved wire level
  output logic [NPINS-1:0] lvl_o
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  logic [NPINS-1:0] float_q = '0;

  // Floating wire must not settle, or stale levels would look valid
  always_ff @(posedge clk_i) begin
    float_q <= ~float_q;
  end

  // Strong driver wins, then outside source, then weak pulls
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (oe_i[i]) lvl_o[i] = out_i[i];
      else if (ext_en_i[i]) lvl_o[i] = ext_lvl_i[i];
      else if (pu_i[i]) lvl_o[i] = 1'b1;
      else if (pd_i[i]) lvl_o[i] = 1'b0;
      else lvl_o[i] = float_q[i];
    end
  end
endmodule : pgp_pin_load

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the packet GPIO port.
// Assumes: Short sample and step counts (20 and 4 cycles).
// Notes: Commands go through send, set_pin and rd tasks.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import pgp_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic save_b = 1'b0;
  logic load_b = 1'b0;
  logic [NPINS-1:0] def_lvl = '0;
  logic [NPINS-1:0] ext_en = '0;
  logic [NPINS-1:0] ext_lvl = '0;
  logic [NPINS-1:0] pin_i, pin_o, pin_oe, pin_pu, pin_pd, pin_slow;
  pgp_cmd_s cmd = '0;
  pgp_rsp_s rsp;
  int fail_count = 0;
  int checks_done = 0;
  logic [7:0] r1, r2, r3;

  pgp_port #(.SAMPLE_CYC(20), .STEP_CYC(4)) u_pgp_port (
    .CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .CMD_I(cmd), .RSP_O(rsp),
    .SAVE_BOOT_I(save_b), .LOAD_BOOT_I(load_b), .DEF_LEVEL_I(def_lvl),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_O(pin_oe), .PIN_PU_O(pin_pu),
    .PIN_PD_O(pin_pd), .PIN_SLOW_O(pin_slow));

  pgp_pin_load u_pgp_pin_load (
    .clk_i(clk), .out_i(pin_o), .oe_i(pin_oe), .pu_i(pin_pu), .pd_i(pin_pd),
    .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .lvl_o(pin_i));

  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // One-cycle command; reply is due exactly one edge later
  task automatic send(input logic [7:0] code, len, d0, d1, d2, input logic exp_v);
    @(posedge clk);
    cmd <= '{1'b1, code, len, d0, d1, d2};
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
    `CHK("reply valid", exp_v, rsp.valid)
  endtask : send

  // Host keeps the config byte within 0..15 and never picks mode 110
  task automatic set_pin(input logic [7:0] idx, lvl, cfg, len);
    send(CODE_SET, len, idx, lvl, cfg & 8'h0F, 1'b1);
    `CHK("ack code", 8'h62, rsp.code)
    `CHK("ack len", LEN_NONE, rsp.len)
  endtask : set_pin

  task automatic rd(input logic [7:0] idx);
    send(CODE_READ, 8'h01, idx, 8'h00, 8'h00, 1'b1);
    `CHK("read code", 8'h63, rsp.code)
    `CHK("read len", LEN_READ_RSP, rsp.len)
    `CHK("read echo", idx, rsp.d0)
    r1 = rsp.d1;
    r2 = rsp.d2;
    r3 = rsp.d3;
  endtask : rd

  task automatic strobe(input bit ld);
    @(posedge clk);
    if (ld) load_b <= 1'b1;
    else save_b <= 1'b1;
    @(posedge clk);
    load_b <= 1'b0;
    save_b <= 1'b0;
  endtask : strobe

  // Expected pad as {oe, out, pu, pd, slow}
  function automatic logic [4:0] pad_exp(input logic hi, input logic [2:0] m);
    case (m)
      3'h0: pad_exp = hi ? 5'h18 : 5'h02;
      3'h1: pad_exp = hi ? 5'h18 : 5'h10;
      3'h3: pad_exp = hi ? 5'h04 : 5'h10;
      3'h4: pad_exp = hi ? 5'h19 : 5'h00;
      3'h5: pad_exp = hi ? 5'h19 : 5'h11;
      3'h7: pad_exp = hi ? 5'h00 : 5'h11;
      default: pad_exp = 5'h00;
    endcase
  endfunction : pad_exp

  // Level and slow edge only matter while the driver is on
  task automatic pads(input int p, input logic [4:0] e);
    `CHK("pad oe", e[4], pin_oe[p])
    `CHK("pad pulls", e[2:1], {pin_pu[p], pin_pd[p]})
    if (e[4]) begin
      `CHK("pad out", e[3], pin_o[p])
      `CHK("pad slow", e[0], pin_slow[p])
    end
  endtask : pads

  task automatic end_sim;
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    end_sim;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] n;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Power-up configuration of every pin
    for (int i = 0; i < NPINS; i++) begin
      rd(i[7:0]);
      `CHK("boot level", LEVEL_DEF, r2)
      `CHK("boot cfg", {4'h0, FUNC_DEF, MODE_DEF[3*i +: 3]}, r3)
    end
    // Every drive mode except reserved 110 at both levels
    for (int k = 0; k < 8; k++) begin
      if (k == 6) continue;
      for (int h = 0; h < 2; h++) begin
        set_pin(8'h00, h[0] ? LEVEL_HIGH : 8'h00, {5'h01, k[2:0]}, LEN_CONFIG);
        @(posedge clk);
        #1;
        pads(0, pad_exp(h[0], k[2:0]));
      end
    end
    // Value-only set keeps the config; bad level is not stored
    set_pin(8'h00, 8'h00, 8'h09, LEN_CONFIG);
    set_pin(8'h00, 8'h32, 8'h0A, LEN_VALUE);
    set_pin(8'h00, 8'h65, 8'h00, LEN_VALUE);
    rd(8'h00);
    `CHK("value only level", 8'h32, r2)
    `CHK("value only cfg", 8'h09, r3)
    // Duty 25 is high for 25 of 100 steps of 4 cycles
    set_pin(8'h00, 8'h19, 8'h00, LEN_VALUE);
    repeat (2) @(posedge clk);
    n = '0;
    // Sample after the edge so the registered pad has settled
    repeat (400) begin
      @(posedge clk);
      #1;
      n = n + {15'h0, pin_o[0]};
    end
    `CHK("pwm high cycles", 16'd100, n)
    // Reserved index is acked and reads back empty
    set_pin(8'h05, 8'h64, 8'h09, LEN_CONFIG);
    rd(8'h05);
    `CHK("reserved state", 8'h00, r1)
    `CHK("reserved cfg", 16'h0000, {r2, r3})
    rd(8'h00);
    `CHK("pin0 untouched", 8'h19, r2)
    send(8'h24, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    // Function bit off follows the default-role level
    @(posedge clk) def_lvl <= 5'h02;
    set_pin(8'h01, 8'h00, 8'h01, LEN_CONFIG);
    @(posedge clk);
    #1;
    `CHK("default role out", 1'b1, pin_o[1])
    `CHK("default role oe", 1'b1, pin_oe[1])
    set_pin(8'h01, 8'h00, 8'h09, LEN_CONFIG);
    @(posedge clk);
    #1;
    `CHK("user role out", 1'b0, pin_o[1])
    // Sampled level and edge flags on an input pin asked to go high
    @(posedge clk) ext_en <= 5'h01;
    set_pin(8'h00, LEVEL_HIGH, 8'h0A, LEN_CONFIG);
    repeat (30) @(posedge clk);
    rd(8'h00);
    repeat (30) @(posedge clk);
    rd(8'h00);
    `CHK("quiet flags", 8'h00, r1)
    `CHK("requested level", LEVEL_HIGH, r2)
    @(posedge clk) ext_lvl <= 5'h01;
    repeat (30) @(posedge clk);
    rd(8'h00);
    `CHK("rise flags", 8'h05, r1)
    @(posedge clk) ext_lvl <= 5'h00;
    repeat (30) @(posedge clk);
    ext_lvl <= 5'h01;
    repeat (30) @(posedge clk);
    rd(8'h00);
    `CHK("both flags", 8'h07, r1)
    rd(8'h00);
    `CHK("flags cleared", 8'h01, r1)
    // Boot copy restore and save
    @(posedge clk) ext_en <= 5'h00;
    strobe(1'b1);
    rd(8'h00);
    `CHK("boot restore cfg", {4'h0, FUNC_DEF, MODE_DEF[2:0]}, r3)
    set_pin(8'h00, 8'h32, 8'h09, LEN_CONFIG);
    strobe(1'b0);
    set_pin(8'h00, 8'h00, 8'h0A, LEN_CONFIG);
    strobe(1'b1);
    rd(8'h00);
    `CHK("saved level", 8'h32, r2)
    `CHK("saved cfg", 8'h09, r3)
    // Enable low: a set is neither answered nor stored
    @(posedge clk) ce <= 1'b0;
    send(CODE_SET, LEN_VALUE, 8'h00, 8'h00, 8'h00, 1'b0);
    @(posedge clk) ce <= 1'b1;
    rd(8'h00);
    `CHK("frozen level", 8'h32, r2)
    end_sim;
  end
endmodule : tb_top
